/* fdw_pkg.sv */
// Shared constants for the flash DMA window parameter block
package fdw_pkg;

  // Bus geometry: byte address is four times the register index
  localparam int IDX_W = 10;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // Register indices
  localparam logic [9:0] IDX_COLOUR_CFG = 10'h05e;
  localparam logic [9:0] IDX_SRC_START0 = 10'h0bc;
  localparam logic [9:0] IDX_SRC_START1 = 10'h0bd;
  localparam logic [9:0] IDX_SRC_START2 = 10'h0be;
  localparam logic [9:0] IDX_SRC_START3 = 10'h0bf;
  localparam logic [9:0] IDX_DEST_X0 = 10'h0c0;
  localparam logic [9:0] IDX_DEST_X1 = 10'h0c1;
  localparam logic [9:0] IDX_DEST_Y0 = 10'h0c2;
  localparam logic [9:0] IDX_DEST_Y1 = 10'h0c3;
  localparam logic [9:0] IDX_RSVD_LO = 10'h0c4;
  localparam logic [9:0] IDX_RSVD_HI = 10'h0c5;
  localparam logic [9:0] IDX_WIDTH0 = 10'h0c6;
  localparam logic [9:0] IDX_WIDTH1 = 10'h0c7;
  localparam logic [9:0] IDX_HEIGHT0 = 10'h0c8;
  localparam logic [9:0] IDX_HEIGHT1 = 10'h0c9;
  localparam logic [9:0] IDX_SRC_WIDTH0 = 10'h0ca;
  localparam logic [9:0] IDX_SRC_WIDTH1 = 10'h0cb;
  localparam logic [9:0] IDX_STATUS = 10'h0e0;

  // Storage slots of the byte registers
  localparam int NUM_BYTES = 15;
  localparam int SLOT_COLOUR = 0;
  localparam int SLOT_SRC0 = 1;
  localparam int SLOT_SRC1 = 2;
  localparam int SLOT_SRC2 = 3;
  localparam int SLOT_SRC3 = 4;
  localparam int SLOT_DX0 = 5;
  localparam int SLOT_DX1 = 6;
  localparam int SLOT_DY0 = 7;
  localparam int SLOT_DY1 = 8;
  localparam int SLOT_W0 = 9;
  localparam int SLOT_W1 = 10;
  localparam int SLOT_H0 = 11;
  localparam int SLOT_H1 = 12;
  localparam int SLOT_SW0 = 13;
  localparam int SLOT_SW1 = 14;

  // Index of each slot
  localparam logic [9:0] SLOT_IDX [NUM_BYTES] = '{
    IDX_COLOUR_CFG, IDX_SRC_START0, IDX_SRC_START1, IDX_SRC_START2, IDX_SRC_START3,
    IDX_DEST_X0, IDX_DEST_X1, IDX_DEST_Y0, IDX_DEST_Y1, IDX_WIDTH0, IDX_WIDTH1,
    IDX_HEIGHT0, IDX_HEIGHT1, IDX_SRC_WIDTH0, IDX_SRC_WIDTH1};

  // Writable bits of each slot
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_SRC_WIDTH_HI = 8'h1f;
  localparam logic [7:0] SLOT_MASK [NUM_BYTES] = '{
    MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL,
    MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL,
    MASK_SRC_WIDTH_HI};

  // Reset value of every byte register
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Field layout
  localparam int MODE_BIT = 2;
  localparam int COORD_W = 13;
  localparam int SIZE_W = 16;
  localparam int WIDE_W = 32;
  localparam int HI_FIELD_W = 5;
  localparam int LIN_ALIGN_W = 2;

  // Status bits
  localparam int STAT_LINEAR_BIT = 0;
  localparam int STAT_EMPTY_BIT = 1;

endpackage

/* fdw_byte_reg.sv */
`timescale 1ns/100ps
`default_nettype none

// One byte of parameter storage with a write mask
module fdw_byte_reg #(
  parameter logic [7:0] WRITE_MASK = 8'hff,
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Write side
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  // Stored value
  output logic [7:0] q
);

  // Stored byte and its next value
  logic [7:0] q_r;
  logic [7:0] q_nxt;

  // Next value: masked bits stay zero
  always_comb
  begin
    q_nxt = q_r;
    if (wrEn)
    begin
      q_nxt = wrData & WRITE_MASK;
    end
  end

  // Register the byte
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q_r <= RESET_VALUE;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire

/* fdw_window_params.sv */
`timescale 1ns/100ps
`default_nettype none

module fdw_window_params (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic [fdw_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fdw_pkg::DATA_W-1:0] pwdata,
  input wire logic [fdw_pkg::STRB_W-1:0] pstrb,
  output logic [fdw_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoded transfer parameters
  output logic linearMode,
  output logic [fdw_pkg::COORD_W-1:0] destX,
  output logic [fdw_pkg::COORD_W-1:0] destY,
  output logic [fdw_pkg::WIDE_W-1:0] destLinearAddr,
  output logic [fdw_pkg::SIZE_W-1:0] blockWidth,
  output logic [fdw_pkg::SIZE_W-1:0] blockHeight,
  output logic [fdw_pkg::WIDE_W-1:0] transferCount,
  output logic [fdw_pkg::COORD_W-1:0] sourceWidth,
  output logic [fdw_pkg::WIDE_W-1:0] flashSourceStart
);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Address decode
  logic [fdw_pkg::IDX_W-1:0] regIdx; // Word index
  logic aligned; // Word-aligned access
  logic [fdw_pkg::NUM_BYTES-1:0] slotHit; // One bit per stored byte
  logic rsvdHit; // Reserved gap
  logic statusHit; // Status word
  logic mapped; // Any known register
  logic setupPh; // APB setup cycle
  logic accessPh; // APB access cycle
  logic wrAccess; // Write takes effect this edge
  logic [7:0] byteQ [fdw_pkg::NUM_BYTES]; // Stored bytes
  logic [7:0] readByte; // Read mux result
  logic linMode; // Mode bit as stored

  assign regIdx = paddr[fdw_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setupPh = psel && !penable;
  assign accessPh = psel && penable;
  assign wrAccess = accessPh && pwrite && pstrb[0];
  assign linMode = byteQ[fdw_pkg::SLOT_COLOUR][fdw_pkg::MODE_BIT];

  // Reserved bytes have no storage
  assign rsvdHit = aligned && ((regIdx == fdw_pkg::IDX_RSVD_LO) ||
                               (regIdx == fdw_pkg::IDX_RSVD_HI));
  assign statusHit = aligned && (regIdx == fdw_pkg::IDX_STATUS);
  assign mapped = (|slotHit) || rsvdHit || statusHit;

  // Byte storage, one instance per slot
  generate
    for (genvar i = 0; i < fdw_pkg::NUM_BYTES; i++)
    begin : g_slot
      assign slotHit[i] = aligned && (regIdx == fdw_pkg::SLOT_IDX[i]);
      fdw_byte_reg #(
        .WRITE_MASK(fdw_pkg::SLOT_MASK[i]),
        .RESET_VALUE(fdw_pkg::BYTE_RESET)
      ) u_byte (
        .clk_sys(clk_sys),
        .rst(rst),
        .wrEn(wrAccess && slotHit[i]),
        .wrData(pwdata[7:0]),
        .q(byteQ[i])
      );
    end
  endgenerate

  // Decoded parameter registers
  logic linearMode_r, linearMode_nxt;
  logic [fdw_pkg::COORD_W-1:0] destX_r, destX_nxt;
  logic [fdw_pkg::COORD_W-1:0] destY_r, destY_nxt;
  logic [fdw_pkg::WIDE_W-1:0] destLinearAddr_r, destLinearAddr_nxt;
  logic [fdw_pkg::SIZE_W-1:0] blockWidth_r, blockWidth_nxt;
  logic [fdw_pkg::SIZE_W-1:0] blockHeight_r, blockHeight_nxt;
  logic [fdw_pkg::WIDE_W-1:0] transferCount_r, transferCount_nxt;
  logic [fdw_pkg::COORD_W-1:0] sourceWidth_r, sourceWidth_nxt;
  logic [fdw_pkg::WIDE_W-1:0] flashSourceStart_r, flashSourceStart_nxt;
  logic [7:0] status_r, status_nxt;

  // Read mux; reserved and unmapped words fall through to zero
  always_comb
  begin
    readByte = 8'h00;
    for (int k = 0; k < fdw_pkg::NUM_BYTES; k++)
    begin
      if (slotHit[k])
      begin
        readByte = byteQ[k];
      end
    end
    if (statusHit)
    begin
      readByte = status_r;
    end
  end

  // Decode: each mode zeroes the fields of the other one
  always_comb
  begin
    linearMode_nxt = linMode;
    destX_nxt = 13'h0000;
    destY_nxt = 13'h0000;
    destLinearAddr_nxt = 32'h00000000;
    blockWidth_nxt = 16'h0000;
    blockHeight_nxt = 16'h0000;
    transferCount_nxt = 32'h00000000;
    status_nxt = 8'h00;
    if (linMode)
    begin
      // Linear: address word from the four destination bytes, low two bits forced
      destLinearAddr_nxt = {byteQ[fdw_pkg::SLOT_DY1], byteQ[fdw_pkg::SLOT_DY0],
                            byteQ[fdw_pkg::SLOT_DX1],
                            byteQ[fdw_pkg::SLOT_DX0][7:fdw_pkg::LIN_ALIGN_W],
                            {fdw_pkg::LIN_ALIGN_W{1'b0}}};
      transferCount_nxt = {byteQ[fdw_pkg::SLOT_H1], byteQ[fdw_pkg::SLOT_H0],
                           byteQ[fdw_pkg::SLOT_W1], byteQ[fdw_pkg::SLOT_W0]};
      status_nxt[fdw_pkg::STAT_EMPTY_BIT] = (transferCount_nxt == 32'h00000000);
    end
    else
    begin
      // Block: coordinates keep only five bits of their high byte
      destX_nxt = {byteQ[fdw_pkg::SLOT_DX1][fdw_pkg::HI_FIELD_W-1:0],
                   byteQ[fdw_pkg::SLOT_DX0]};
      destY_nxt = {byteQ[fdw_pkg::SLOT_DY1][fdw_pkg::HI_FIELD_W-1:0],
                   byteQ[fdw_pkg::SLOT_DY0]};
      blockWidth_nxt = {byteQ[fdw_pkg::SLOT_W1], byteQ[fdw_pkg::SLOT_W0]};
      blockHeight_nxt = {byteQ[fdw_pkg::SLOT_H1], byteQ[fdw_pkg::SLOT_H0]};
      status_nxt[fdw_pkg::STAT_EMPTY_BIT] = (blockWidth_nxt == 16'h0000) ||
                                            (blockHeight_nxt == 16'h0000);
    end
    // Mode-independent fields
    sourceWidth_nxt = {byteQ[fdw_pkg::SLOT_SW1][fdw_pkg::HI_FIELD_W-1:0],
                       byteQ[fdw_pkg::SLOT_SW0]};
    flashSourceStart_nxt = {byteQ[fdw_pkg::SLOT_SRC3], byteQ[fdw_pkg::SLOT_SRC2],
                            byteQ[fdw_pkg::SLOT_SRC1], byteQ[fdw_pkg::SLOT_SRC0]};
    status_nxt[fdw_pkg::STAT_LINEAR_BIT] = linMode;
  end

  // Register decoded parameters
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      linearMode_r <= 1'b0;
      destX_r <= 13'h0000;
      destY_r <= 13'h0000;
      destLinearAddr_r <= 32'h00000000;
      blockWidth_r <= 16'h0000;
      blockHeight_r <= 16'h0000;
      transferCount_r <= 32'h00000000;
      sourceWidth_r <= 13'h0000;
      flashSourceStart_r <= 32'h00000000;
      status_r <= 8'h00;
    end
    else
    begin
      linearMode_r <= linearMode_nxt;
      destX_r <= destX_nxt;
      destY_r <= destY_nxt;
      destLinearAddr_r <= destLinearAddr_nxt;
      blockWidth_r <= blockWidth_nxt;
      blockHeight_r <= blockHeight_nxt;
      transferCount_r <= transferCount_nxt;
      sourceWidth_r <= sourceWidth_nxt;
      flashSourceStart_r <= flashSourceStart_nxt;
      status_r <= status_nxt;
    end
  end

  // Read data register: captured in setup, stable through access
  logic [fdw_pkg::DATA_W-1:0] prdata_r, prdata_nxt;

  always_comb
  begin
    prdata_nxt = prdata_r;
    if (setupPh && !pwrite)
    begin
      prdata_nxt = {24'h000000, readByte};
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prdata_r <= 32'h00000000;
    end
    else
    begin
      prdata_r <= prdata_nxt;
    end
  end

  // Bus answers: zero wait states, error on unknown or misaligned words
  assign pready = accessPh;
  assign pslverr = accessPh && !mapped;
  assign prdata = prdata_r;

  // Parameter outputs
  assign linearMode = linearMode_r;
  assign destX = destX_r;
  assign destY = destY_r;
  assign destLinearAddr = destLinearAddr_r;
  assign blockWidth = blockWidth_r;
  assign blockHeight = blockHeight_r;
  assign transferCount = transferCount_r;
  assign sourceWidth = sourceWidth_r;
  assign flashSourceStart = flashSourceStart_r;

  // Reserved access steps
  sequence s_rsvd_read_setup;
    setupPh && !pwrite && rsvdHit;
  endsequence

  sequence s_access_done;
    accessPh && pready;
  endsequence

  a_mode_select: assert property (1'b1 |=> (linearMode ==
      $past(byteQ[fdw_pkg::SLOT_COLOUR][fdw_pkg::MODE_BIT])) &&
      (!linearMode || (destX == 13'h0000 && blockHeight == 16'h0000)) &&
      (linearMode || transferCount == 32'h00000000))
    else $error("mode bit not followed");

  a_block_x_map: assert property (!linMode |=> destX ==
      {$past(byteQ[fdw_pkg::SLOT_DX1][4:0]), $past(byteQ[fdw_pkg::SLOT_DX0])})
    else $error("block X coordinate wrong");

  a_lin_low_addr: assert property (linMode |=> destLinearAddr[15:2] ==
      {$past(byteQ[fdw_pkg::SLOT_DX1]), $past(byteQ[fdw_pkg::SLOT_DX0][7:2])})
    else $error("linear address low part wrong");

  a_block_y_map: assert property (!linMode |=> destY ==
      {$past(byteQ[fdw_pkg::SLOT_DY1][4:0]), $past(byteQ[fdw_pkg::SLOT_DY0])})
    else $error("block Y coordinate wrong");

  a_lin_high_addr: assert property (linMode |=> destLinearAddr[31:16] ==
      {$past(byteQ[fdw_pkg::SLOT_DY1]), $past(byteQ[fdw_pkg::SLOT_DY0])})
    else $error("linear address high part wrong");

  a_block_width: assert property (!linMode |=> blockWidth ==
      {$past(byteQ[fdw_pkg::SLOT_W1]), $past(byteQ[fdw_pkg::SLOT_W0])})
    else $error("block width wrong");

  a_block_height: assert property (!linMode |=> blockHeight ==
      {$past(byteQ[fdw_pkg::SLOT_H1]), $past(byteQ[fdw_pkg::SLOT_H0])})
    else $error("block height wrong");

  a_count_join: assert property (linMode |=> transferCount ==
      {$past(byteQ[fdw_pkg::SLOT_H1]), $past(byteQ[fdw_pkg::SLOT_H0]),
       $past(byteQ[fdw_pkg::SLOT_W1]), $past(byteQ[fdw_pkg::SLOT_W0])})
    else $error("transfer count wrong");

  // One cycle of history first, so the first sample after reset is not compared
  a_src_width_hi: assert property (1'b1 |=> byteQ[fdw_pkg::SLOT_SW1][7:5] == 3'h0 &&
      (sourceWidth_r[12:8] == $past(byteQ[fdw_pkg::SLOT_SW1][4:0])))
    else $error("source width high bits wrong");

  a_rsvd_read_zero: assert property (s_rsvd_read_setup ##1 s_access_done
      |-> prdata == 32'h00000000 && !pslverr)
    else $error("reserved read not zero");

  a_rsvd_write_none: assert property (accessPh && pwrite && rsvdHit
      |=> $stable(transferCount) && $stable(destLinearAddr) &&
          $stable(flashSourceStart) && $stable(sourceWidth))
    else $error("reserved write changed state");

  a_flash_start: assert property (1'b1 |=> flashSourceStart ==
      {$past(byteQ[fdw_pkg::SLOT_SRC3]), $past(byteQ[fdw_pkg::SLOT_SRC2]),
       $past(byteQ[fdw_pkg::SLOT_SRC1]), $past(byteQ[fdw_pkg::SLOT_SRC0])})
    else $error("flash source start wrong");

  a_lin_aligned: assert property (destLinearAddr[1:0] == 2'h0)
    else $error("linear address not word aligned");

endmodule

`default_nettype wire

/* fdw_apb_host.sv */
`timescale 1ns/100ps
`default_nettype none

// Host side of the register bus, one transfer at a time
module fdw_apb_host (
  // Clock
  input wire logic clk_sys,
  // Request side
  output var logic [fdw_pkg::ADDR_W-1:0] paddr,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [fdw_pkg::DATA_W-1:0] pwdata,
  output var logic [fdw_pkg::STRB_W-1:0] pstrb,
  // Answer side
  input wire logic [fdw_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle from time zero
  initial
  begin
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    pstrb = '0;
  end

  // One transfer: setup, access until ready, then release
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
    output logic [31:0] rd, output logic err);
    // Setup cycle with address, direction and data
    @(posedge clk_sys);
    paddr <= {idx, 2'b00};
    psel <= 1'b1;
    pwrite <= wr;
    pwdata <= {24'h000000, wd};
    pstrb <= 4'hf;
    // Access phase held until ready is seen
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // No cap here: the bench's own cycle limit ends a hung wait
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    // Answer taken at the ready edge
    rd = prdata;
    err = pslverr;
    // Release; stale write data is not left on the bus
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
endmodule

`default_nettype wire

/* flash_dma_window_params_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

// Self-checking bench for the window parameter block
module flash_dma_window_params_tb_top;
  // Clock, reset and bus wires
  logic clk_sys;
  logic rst;
  logic [11:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  // Decoded parameters
  logic linearMode;
  logic [12:0] destX, destY, sourceWidth;
  logic [15:0] blockWidth, blockHeight;
  logic [31:0] destLinearAddr, transferCount, flashSourceStart;
  // Bookkeeping
  int numErrors = 0;
  int checkCount = 0;
  int cycles = 0;
  logic [31:0] rdData;
  logic busErr;

  // Design under test
  fdw_window_params uut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .linearMode(linearMode), .destX(destX),
    .destY(destY), .destLinearAddr(destLinearAddr), .blockWidth(blockWidth),
    .blockHeight(blockHeight), .transferCount(transferCount), .sourceWidth(sourceWidth),
    .flashSourceStart(flashSourceStart));

  // Bus master model
  fdw_apb_host host (.clk_sys(clk_sys), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // 250 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic endSim();
    if (numErrors == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare one value, report a mismatch
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write one byte register, compare the error answer with expErr
  task automatic wrReg(input logic [9:0] idx, input logic [7:0] d, input logic expErr);
    host.xfer(1'b1, idx, d, rdData, busErr);
    check("write error", {31'h0, busErr}, {31'h0, expErr});
  endtask

  // Read one register, compare data and error
  task automatic rdReg(input logic [9:0] idx, input logic [31:0] exp, input logic expErr);
    host.xfer(1'b0, idx, 8'h00, rdData, busErr);
    check("read data", rdData, exp);
    check("read error", {31'h0, busErr}, {31'h0, expErr});
  endtask

  // Let decoded outputs settle after the last write
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      numErrors++;
      endSim();
    end
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values of all bytes and the upper reserved byte
    for (int i = 0; i < fdw_pkg::NUM_BYTES; i++)
      rdReg(fdw_pkg::SLOT_IDX[i], 32'h0, 1'b0);
    rdReg(fdw_pkg::IDX_RSVD_HI, 32'h0, 1'b0);
    // Status after reset: block mode with zero size
    rdReg(fdw_pkg::IDX_STATUS, 32'h2, 1'b0);
    // Block mode fields, unused high bits set
    wrReg(fdw_pkg::IDX_DEST_X0, 8'h34, 1'b0);
    wrReg(fdw_pkg::IDX_DEST_X1, 8'hff, 1'b0);
    wrReg(fdw_pkg::IDX_DEST_Y0, 8'h56, 1'b0);
    wrReg(fdw_pkg::IDX_DEST_Y1, 8'he7, 1'b0);
    wrReg(fdw_pkg::IDX_WIDTH0, 8'h34, 1'b0);
    wrReg(fdw_pkg::IDX_WIDTH1, 8'h12, 1'b0);
    wrReg(fdw_pkg::IDX_HEIGHT0, 8'hcd, 1'b0);
    wrReg(fdw_pkg::IDX_HEIGHT1, 8'hab, 1'b0);
    wrReg(fdw_pkg::IDX_SRC_WIDTH0, 8'h78, 1'b0);
    wrReg(fdw_pkg::IDX_SRC_WIDTH1, 8'hff, 1'b0);
    // Reserved bytes ignore writes and read zero
    wrReg(fdw_pkg::IDX_RSVD_LO, 8'hff, 1'b0);
    wrReg(fdw_pkg::IDX_RSVD_HI, 8'hff, 1'b0);
    rdReg(fdw_pkg::IDX_RSVD_LO, 32'h0, 1'b0);
    rdReg(fdw_pkg::IDX_RSVD_HI, 32'h0, 1'b0);
    // Flash source start, lowest byte first
    wrReg(fdw_pkg::IDX_SRC_START0, 8'h11, 1'b0);
    wrReg(fdw_pkg::IDX_SRC_START1, 8'h22, 1'b0);
    wrReg(fdw_pkg::IDX_SRC_START2, 8'h33, 1'b0);
    wrReg(fdw_pkg::IDX_SRC_START3, 8'h44, 1'b0);
    settle();
    check("linearMode", 32'(linearMode), 32'h0);
    check("destX", 32'(destX), 32'h00001f34);
    check("destY", 32'(destY), 32'h00000756);
    check("blockWidth", 32'(blockWidth), 32'h00001234);
    check("blockHeight", 32'(blockHeight), 32'h0000abcd);
    check("sourceWidth", 32'(sourceWidth), 32'h00001f78);
    check("flashSourceStart", flashSourceStart, 32'h44332211);
    check("destLinearAddr", destLinearAddr, 32'h0);
    check("transferCount", transferCount, 32'h0);
    rdReg(fdw_pkg::IDX_SRC_WIDTH1, 32'h1f, 1'b0);
    // Switch to linear mode through bit 2 only
    wrReg(fdw_pkg::IDX_COLOUR_CFG, 8'h04, 1'b0);
    settle();
    check("linearMode", 32'(linearMode), 32'h1);
    check("destLinearAddr", destLinearAddr, 32'he756ff34);
    check("transferCount", transferCount, 32'habcd1234);
    check("destX", 32'(destX), 32'h0);
    check("blockWidth", 32'(blockWidth), 32'h0);
    check("destY", 32'(destY), 32'h0);
    check("blockHeight", 32'(blockHeight), 32'h0);
    check("sourceWidth", 32'(sourceWidth), 32'h00001f78);
    // Status: linear flag set, count not zero
    rdReg(fdw_pkg::IDX_STATUS, 32'h1, 1'b0);
    // Low address bits stored but not used by the linear address
    wrReg(fdw_pkg::IDX_DEST_X0, 8'h37, 1'b0);
    settle();
    check("destLinearAddr", destLinearAddr, 32'he756ff34);
    rdReg(fdw_pkg::IDX_DEST_X0, 32'h37, 1'b0);
    // Back to block mode with all other bits set
    wrReg(fdw_pkg::IDX_COLOUR_CFG, 8'hfb, 1'b0);
    settle();
    check("linearMode", 32'(linearMode), 32'h0);
    check("destX", 32'(destX), 32'h00001f37);
    check("transferCount", transferCount, 32'h0);
    // Unmapped place answers with an error
    rdReg(10'h001, 32'h0, 1'b1);
    wrReg(10'h001, 8'h5a, 1'b1);
    // Mid-run reset clears stored bytes and decoded fields
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    check("flashSourceStart", flashSourceStart, 32'h0);
    check("sourceWidth", 32'(sourceWidth), 32'h0);
    check("blockWidth", 32'(blockWidth), 32'h0);
    check("linearMode", 32'(linearMode), 32'h0);
    rdReg(fdw_pkg::IDX_COLOUR_CFG, 32'h0, 1'b0);
    endSim();
  end
endmodule

`default_nettype wire
